// [design/bce_map.svh]
// Register indices, field positions, reset values and cycle counts of the byte-wide cipher engine.
// Assumes inclusion by the engine top; holds definitions only.
`ifndef BCE_MAP_SVH
`define BCE_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define BCE_IDX_CONTROL   2'h0
`define BCE_IDX_STATUS    2'h1
`define BCE_IDX_DATA_IN   2'h2
`define BCE_IDX_DATA_OUT  2'h3

// Control register fields.
`define BCE_CTL_ENABLE    0
`define BCE_CTL_MODE_LO   1
`define BCE_CTL_MODE_HI   2
`define BCE_CTL_DONE_CLR  3
`define BCE_CTL_FAULT_CLR 4
`define BCE_CTL_DONE_IE   5
`define BCE_CTL_FAULT_IE  6
`define BCE_CTL_DMA_EN    7
`define BCE_CTL_RESET     8'h00

// Status register fields.
`define BCE_STA_DONE      0
`define BCE_STA_BAD_RD    1
`define BCE_STA_BAD_WR    2
`define BCE_STA_RESET     8'h00

// Computation phase length in clock cycles for each operation.
`define BCE_CYC_ENCRYPT   892
`define BCE_CYC_KEYDERIV  320
`define BCE_CYC_DECRYPT   892
`define BCE_CYC_KDDECRYPT 1228

// Byte counts of the input and output phases, and the number of cipher rounds.
`define BCE_BYTES_BLOCK   16
`define BCE_BYTES_DOUBLE  32
`define BCE_AES_ROUNDS    10

`endif

// [design/bce_pkg.sv]
// Types shared by the byte-wide cipher engine.
// Assumes nothing of its surroundings.
package bce_pkg;

   typedef enum logic [1:0] {
      BCE_OP_ENCRYPT   = 2'b00,
      BCE_OP_KEYDERIV  = 2'b01,
      BCE_OP_DECRYPT   = 2'b10,
      BCE_OP_KDDECRYPT = 2'b11
   } bce_op_t;

   typedef enum logic [1:0] {
      BCE_PH_OFF    = 2'b00,
      BCE_PH_INPUT  = 2'b01,
      BCE_PH_CALC   = 2'b10,
      BCE_PH_OUTPUT = 2'b11
   } bce_phase_t;

endpackage

// [design/bce_engine.sv]
// Byte-wide AES-128 engine with an APB register slave and two DMA request lines.
// Assumes a single 200 MHz clock, an APB master on the same clock and a DMA controller that
// serves level requests.
`timescale 1ns/1ps
`include "bce_map.svh"

module bce_engine
   import bce_pkg::*;
#(
   parameter int ADDR_W        = 8,
   parameter int CYC_ENCRYPT   = `BCE_CYC_ENCRYPT,
   parameter int CYC_KEYDERIV  = `BCE_CYC_KEYDERIV,
   parameter int CYC_DECRYPT   = `BCE_CYC_DECRYPT,
   parameter int CYC_KDDECRYPT = `BCE_CYC_KDDECRYPT
) (
   // Clock and reset
   input  wire logic              CORE_CLK_I,
   input  wire logic              SYS_RST_I,
   // APB slave
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output logic      [31:0]       PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   // Interrupt and DMA requests
   output logic                   IRQ_O,
   output logic                   DMA_IN_REQ_O,
   output logic                   DMA_OUT_REQ_O
);

   // The schedule needs 21 working cycles at most; each count must exceed the working cycles of its own mode.
   initial begin
      if (ADDR_W < 4 || CYC_ENCRYPT < 12 || CYC_DECRYPT < 12 || CYC_KEYDERIV < 11 ||
          CYC_KDDECRYPT < 22 || CYC_KDDECRYPT > 2047 || CYC_ENCRYPT > 2047 ||
          CYC_DECRYPT > 2047 || CYC_KEYDERIV > 2047) begin
         $error("bce_engine: parameter out of range");
      end
   end

   function automatic logic [7:0] xt(input logic [7:0] b);
      return {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
   endfunction

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            p = p ^ x;
         end
         x = xt(x);
      end
      return p;
   endfunction

   // Field inverse as b^254; zero maps to zero as the cipher requires.
   function automatic logic [7:0] ginv(input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] r;
      p = b;
      r = 8'h01;
      for (int i = 1; i < 8; i++) begin
         p = gmul(p, p);
         r = gmul(r, p);
      end
      return r;
   endfunction

   function automatic logic [7:0] rl(input logic [7:0] b, input int n);
      logic [15:0] t;
      t = {b, b} << n;
      return t[15:8];
   endfunction

   // The substitution tables are computed rather than stored, trading logic depth for lines.
   function automatic logic [7:0] sbox(input logic [7:0] b);
      logic [7:0] i;
      i = ginv(b);
      return i ^ rl(i, 1) ^ rl(i, 2) ^ rl(i, 3) ^ rl(i, 4) ^ 8'h63;
   endfunction

   function automatic logic [7:0] isbox(input logic [7:0] b);
      return ginv(rl(b, 1) ^ rl(b, 3) ^ rl(b, 6) ^ 8'h05);
   endfunction

   function automatic logic [7:0] rcon(input logic [3:0] idx);
      logic [7:0] r;
      r = 8'h01;
      for (int k = 1; k < 11; k++) begin
         if (4'(k) < idx) begin
            r = xt(r);
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] subrot(input logic [31:0] w, input logic [3:0] idx);
      return {sbox(w[23:16]) ^ rcon(idx), sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
   endfunction

   function automatic logic [127:0] key_fwd(input logic [127:0] k, input logic [3:0] idx);
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic [31:0] w3;
      w0 = k[127:96] ^ subrot(k[31:0], idx);
      w1 = k[95:64] ^ w0;
      w2 = k[63:32] ^ w1;
      w3 = k[31:0] ^ w2;
      return {w0, w1, w2, w3};
   endfunction

   function automatic logic [127:0] key_bwd(input logic [127:0] k, input logic [3:0] idx);
      logic [31:0] w3;
      w3 = k[31:0] ^ k[63:32];
      return {k[127:96] ^ subrot(w3, idx), k[127:96] ^ k[95:64], k[95:64] ^ k[63:32], w3};
   endfunction

   function automatic logic [127:0] enc_round(input logic [127:0] s, input logic last);
      logic [7:0]   t [16];
      logic [127:0] o;
      o = '0;
      for (int k = 0; k < 16; k++) begin
         t[k] = sbox(s[127 - 8 * (4 * (((k / 4) + (k % 4)) % 4) + (k % 4)) -: 8]);
      end
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            o[127 - 8 * (4 * c + r) -: 8] = last ? t[4 * c + r] :
               xt(t[4 * c + r]) ^ xt(t[4 * c + (r + 1) % 4]) ^ t[4 * c + (r + 1) % 4] ^
               t[4 * c + (r + 2) % 4] ^ t[4 * c + (r + 3) % 4];
         end
      end
      return o;
   endfunction

   function automatic logic [127:0] dec_round(input logic [127:0] s, input logic [127:0] rk,
                                               input logic last);
      logic [7:0]   t [16];
      logic [127:0] o;
      o = '0;
      for (int k = 0; k < 16; k++) begin
         t[k] = isbox(s[127 - 8 * (4 * (((k / 4) + 4 - (k % 4)) % 4) + (k % 4)) -: 8]) ^
                rk[127 - 8 * k -: 8];
      end
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            o[127 - 8 * (4 * c + r) -: 8] = last ? t[4 * c + r] :
               gmul(t[4 * c + r], 8'h0e) ^ gmul(t[4 * c + (r + 1) % 4], 8'h0b) ^
               gmul(t[4 * c + (r + 2) % 4], 8'h0d) ^ gmul(t[4 * c + (r + 3) % 4], 8'h09);
         end
      end
      return o;
   endfunction

   // Control register and engine state.
   logic             enable_q;
   bce_op_t          mode_q;
   logic             calc_done_irq_enable_q;
   logic             fault_irq_enable_q;
   logic             dma_transfer_enable_q;
   logic             calc_done_flag_q;
   logic             bad_read_flag_q;
   logic             bad_write_flag_q;
   bce_phase_t       phase_q;
   logic [5:0]       in_cnt_q;
   logic [3:0]       out_cnt_q;
   logic [10:0]      cyc_q;
   logic [7:0]       din_q;
   logic             din_vld_q;
   logic [7:0]       dout_q;
   logic [127:0]     key_q;
   logic [127:0]     state_q;

   // Bus decode.
   logic             acc;
   logic             wr_acc;
   logic             rd_acc;
   logic [1:0]       idx;
   logic             mapped;
   logic             ctl_wr;
   logic             din_wr;
   logic             dout_rd;
   logic [7:0]       wbyte;

   assign idx    = PADDR_I[3:2];
   assign mapped = (PADDR_I[1:0] == 2'b00) && ((PADDR_I >> 4) == '0);
   assign acc    = PSEL_I && PENABLE_I && PREADY_O;
   assign wr_acc = acc && PWRITE_I && mapped;
   assign rd_acc = acc && !PWRITE_I && mapped;
   assign ctl_wr  = wr_acc && (idx == `BCE_IDX_CONTROL);
   assign din_wr  = wr_acc && (idx == `BCE_IDX_DATA_IN);
   assign dout_rd = rd_acc && (idx == `BCE_IDX_DATA_OUT);
   assign wbyte   = PWDATA_I[7:0];

   // Schedule inside the computation phase.
   logic [10:0]      cyc_total;
   logic [10:0]      kd_len;
   logic [10:0]      cstep;
   logic             has_cipher;
   logic             is_dec;
   logic             last_byte_in;

   always_comb begin
      unique case (mode_q)
         BCE_OP_ENCRYPT:   cyc_total = 11'(CYC_ENCRYPT);
         BCE_OP_KEYDERIV:  cyc_total = 11'(CYC_KEYDERIV);
         BCE_OP_DECRYPT:   cyc_total = 11'(CYC_DECRYPT);
         BCE_OP_KDDECRYPT: cyc_total = 11'(CYC_KDDECRYPT);
      endcase
   end

   assign kd_len     = (mode_q == BCE_OP_KEYDERIV || mode_q == BCE_OP_KDDECRYPT) ? 11'd10 : 11'd0;
   assign has_cipher = (mode_q != BCE_OP_KEYDERIV);
   assign is_dec     = mode_q[1];
   assign cstep      = cyc_q - kd_len;
   // Derivation alone takes one 16-byte key; the other operations take key plus block.
   assign last_byte_in = (mode_q == BCE_OP_KEYDERIV) ? (in_cnt_q == 6'(`BCE_BYTES_BLOCK - 1)) :
                         (in_cnt_q == 6'(`BCE_BYTES_DOUBLE - 1));

   // Control register; the clear bits are pulses and never stored.
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         enable_q               <= 1'b0;
         mode_q                 <= BCE_OP_ENCRYPT;
         calc_done_irq_enable_q <= 1'b0;
         fault_irq_enable_q     <= 1'b0;
         dma_transfer_enable_q  <= 1'b0;
      end else if (ctl_wr) begin
         enable_q               <= wbyte[`BCE_CTL_ENABLE];
         mode_q                 <= bce_op_t'(wbyte[`BCE_CTL_MODE_HI:`BCE_CTL_MODE_LO]);
         calc_done_irq_enable_q <= wbyte[`BCE_CTL_DONE_IE];
         fault_irq_enable_q     <= wbyte[`BCE_CTL_FAULT_IE];
         dma_transfer_enable_q  <= wbyte[`BCE_CTL_DMA_EN];
      end
   end

   // Phase sequencing.
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         phase_q   <= BCE_PH_OFF;
         in_cnt_q  <= '0;
         out_cnt_q <= '0;
         cyc_q     <= '0;
      end else if (!enable_q) begin
         phase_q   <= BCE_PH_OFF;
         in_cnt_q  <= '0;
         out_cnt_q <= '0;
         cyc_q     <= '0;
      end else begin
         unique case (phase_q)
            BCE_PH_OFF: begin
               phase_q <= BCE_PH_INPUT;
            end
            BCE_PH_INPUT: begin
               if (din_vld_q) begin
                  in_cnt_q <= in_cnt_q + 6'd1;
                  if (last_byte_in) begin
                     phase_q  <= BCE_PH_CALC;
                     in_cnt_q <= '0;
                     cyc_q    <= '0;
                  end
               end
            end
            BCE_PH_CALC: begin
               cyc_q <= cyc_q + 11'd1;
               if (cyc_q == cyc_total - 11'd1) begin
                  phase_q   <= BCE_PH_OUTPUT;
                  out_cnt_q <= '0;
               end
            end
            BCE_PH_OUTPUT: begin
               if (dout_rd) begin
                  out_cnt_q <= out_cnt_q + 4'd1;
                  if (out_cnt_q == 4'(`BCE_BYTES_BLOCK - 1)) begin
                     phase_q <= BCE_PH_INPUT;
                  end
               end
            end
         endcase
      end
   end

   // One-byte input buffer; writes outside the input phase never reach it.
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         din_q     <= 8'h00;
         din_vld_q <= 1'b0;
      end else if (din_wr && phase_q == BCE_PH_INPUT && enable_q && !din_vld_q) begin
         din_q     <= wbyte;
         din_vld_q <= 1'b1;
      end else begin
         din_vld_q <= 1'b0;
      end
   end

   // Datapath: key and block shift in most significant byte first, and the result shifts out the same way.
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         key_q   <= '0;
         state_q <= '0;
         dout_q  <= 8'h00;
      end else if (enable_q && phase_q == BCE_PH_INPUT && din_vld_q) begin
         if (in_cnt_q < 6'(`BCE_BYTES_BLOCK)) begin
            key_q <= {key_q[119:0], din_q};
         end else begin
            state_q <= {state_q[119:0], din_q};
         end
      end else if (enable_q && phase_q == BCE_PH_CALC) begin
         if (cyc_q < kd_len) begin
            key_q <= key_fwd(key_q, 4'(cyc_q + 11'd1));
         end else if (has_cipher && cstep == 11'd0) begin
            state_q <= state_q ^ key_q;
         end else if (has_cipher && cstep <= 11'(`BCE_AES_ROUNDS) && !is_dec) begin
            key_q   <= key_fwd(key_q, 4'(cstep));
            state_q <= enc_round(state_q, cstep == 11'(`BCE_AES_ROUNDS)) ^ key_fwd(key_q, 4'(cstep));
         end else if (has_cipher && cstep <= 11'(`BCE_AES_ROUNDS)) begin
            key_q   <= key_bwd(key_q, 4'(11'd11 - cstep));
            state_q <= dec_round(state_q, key_bwd(key_q, 4'(11'd11 - cstep)),
                                 cstep == 11'(`BCE_AES_ROUNDS));
         end
         if (cyc_q == cyc_total - 11'd1) begin
            // The derived key is the result of a derivation-only run.
            if (!has_cipher) begin
               state_q <= key_q << 8;
               dout_q  <= key_q[127:120];
            end else begin
               state_q <= state_q << 8;
               dout_q  <= state_q[127:120];
            end
         end
      end else if (enable_q && phase_q == BCE_PH_OUTPUT && dout_rd) begin
         dout_q  <= state_q[127:120];
         state_q <= state_q << 8;
      end
   end

   // Status flags; a hardware set in the same cycle as a software clear wins.
   logic done_set;
   logic bad_rd_set;
   logic bad_wr_set;
   logic done_clr;
   logic fault_clr;

   assign done_set   = enable_q && phase_q == BCE_PH_CALC && cyc_q == cyc_total - 11'd1;
   assign bad_rd_set = dout_rd && enable_q && (phase_q == BCE_PH_INPUT || phase_q == BCE_PH_CALC);
   assign bad_wr_set = din_wr && enable_q && (phase_q == BCE_PH_OUTPUT || phase_q == BCE_PH_CALC);
   assign done_clr   = ctl_wr && wbyte[`BCE_CTL_DONE_CLR];
   assign fault_clr  = ctl_wr && wbyte[`BCE_CTL_FAULT_CLR];

   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         calc_done_flag_q <= 1'b0;
         bad_read_flag_q  <= 1'b0;
         bad_write_flag_q <= 1'b0;
      end else begin
         calc_done_flag_q <= done_set | (calc_done_flag_q & ~done_clr);
         bad_read_flag_q  <= bad_rd_set | (bad_read_flag_q & ~fault_clr);
         bad_write_flag_q <= bad_wr_set | (bad_write_flag_q & ~fault_clr);
      end
   end

   // Interrupt and DMA requests. Under DMA the done flag plays no part in pacing.
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         IRQ_O         <= 1'b0;
         DMA_IN_REQ_O  <= 1'b0;
         DMA_OUT_REQ_O <= 1'b0;
      end else begin
         IRQ_O <= (calc_done_flag_q & calc_done_irq_enable_q) |
                  ((bad_read_flag_q | bad_write_flag_q) & fault_irq_enable_q);
         // A request drops as soon as its transfer is taken, so one byte is never asked for twice.
         DMA_IN_REQ_O  <= dma_transfer_enable_q && enable_q && phase_q == BCE_PH_INPUT &&
                          !din_vld_q && !din_wr;
         DMA_OUT_REQ_O <= dma_transfer_enable_q && enable_q && phase_q == BCE_PH_OUTPUT &&
                          !dout_rd;
      end
   end

   // APB answer: one wait-free access phase, read data captured in the setup cycle.
   logic [7:0] rbyte;

   always_comb begin
      unique case (idx)
         `BCE_IDX_CONTROL:  rbyte = {dma_transfer_enable_q, fault_irq_enable_q, calc_done_irq_enable_q,
                                     2'b00, mode_q, enable_q};
         `BCE_IDX_STATUS:   rbyte = {5'h00, bad_write_flag_q, bad_read_flag_q, calc_done_flag_q};
         `BCE_IDX_DATA_IN:  rbyte = 8'h00;
         `BCE_IDX_DATA_OUT: rbyte = dout_q;
      endcase
   end

   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h0000_0000;
      end else begin
         PREADY_O  <= PSEL_I && !PENABLE_I;
         PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped;
         if (PSEL_I && !PENABLE_I && !PWRITE_I && mapped) begin
            PRDATA_O <= {24'h00_0000, rbyte};
         end else if (!PSEL_I) begin
            PRDATA_O <= 32'h0000_0000;
         end
      end
   end

endmodule // bce_engine

// [dv/bce_engine_asserts.sv]
// Concurrent checks on the cipher engine's bus and DMA ports, and covers on its DMA, interrupt and error ports.
// Assumes binding to bce_engine; sees only its ports.
`timescale 1ns/1ps
module bce_engine_asserts #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic              CORE_CLK_I,
   input wire logic              SYS_RST_I,
   // Bus and requests
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0]       PWDATA_I,
   input wire logic [31:0]       PRDATA_O,
   input wire logic              PREADY_O,
   input wire logic              PSLVERR_O,
   input wire logic              IRQ_O,
   input wire logic              DMA_IN_REQ_O,
   input wire logic              DMA_OUT_REQ_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   wire logic       hi0  = ~|(PADDR_I >> 4);
   wire logic [3:0] lo   = PADDR_I[3:0];
   wire logic       take = PSEL_I & PENABLE_I & PREADY_O;
   wire logic       rd   = PREADY_O & ~PWRITE_I & hi0;
   property p_ready; PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O; endproperty
   a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
   property p_map; PREADY_O |-> PSLVERR_O == (!hi0 || lo[1:0] != 2'h0); endproperty
   a_map: assert property (p_map) else $error("slave error wrong for address");
   property p_err_rdy; PSLVERR_O |-> PREADY_O; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("slave error without ready");
   property p_byte; PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0; endproperty
   a_byte: assert property (p_byte) else $error("read data above byte lane");
   property p_clr0; rd && lo == 4'h0 |-> PRDATA_O[4:3] == 2'b00; endproperty
   a_clr0: assert property (p_clr0) else $error("clear bits read as one");
   property p_din0; rd && lo == 4'h8 |-> PRDATA_O == 32'h0; endproperty
   a_din0: assert property (p_din0) else $error("data in reads nonzero");
   property p_dma_x; !(DMA_IN_REQ_O && DMA_OUT_REQ_O); endproperty
   a_dma_x: assert property (p_dma_x) else $error("both DMA requests high");
   property p_in_drop; take && PWRITE_I && lo == 4'h8 && DMA_IN_REQ_O |=> !DMA_IN_REQ_O; endproperty
   a_in_drop: assert property (p_in_drop) else $error("input request held after write");
   property p_out_drop; take && !PWRITE_I && lo == 4'hc && DMA_OUT_REQ_O |=> !DMA_OUT_REQ_O; endproperty
   a_out_drop: assert property (p_out_drop) else $error("output request held after read");
   c_in: cover property (DMA_IN_REQ_O);
   c_out: cover property (DMA_OUT_REQ_O);
   c_irq: cover property (IRQ_O);
   c_err: cover property (PSLVERR_O);
endmodule // bce_engine_asserts

bind bce_engine bce_engine_asserts #(.ADDR_W(ADDR_W)) u_asserts (
   .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O), .DMA_IN_REQ_O(DMA_IN_REQ_O),
   .DMA_OUT_REQ_O(DMA_OUT_REQ_O));

// [dv/bce_cpu_model.sv]
// Processor model: the bus master that feeds and drains the cipher engine.
// Assumes the engine's bus slave on the same clock; callers use its xfer task.
`timescale 1ns/1ps
module bce_cpu_model (
   // Clock and answer
   input  wire logic        clk_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   // Request
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o,
   output logic             tmo_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
      tmo_o = 1'b0;
   end
   // Every transfer opens one edge late, so there is always a gap the engine must ride out.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 50);
      q = prdata_i;
      if (n >= 50) tmo_o = 1'b1;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~d;
   endtask
endmodule // bce_cpu_model

// [dv/byte_wide_block_cipher_engine_tb.sv]
// Self-checking bench for the cipher engine: all modes, errors, restart and DMA flow.
// Assumes the processor model as bus master and shortened computation counts.
`timescale 1ns/1ps
module byte_wide_block_cipher_engine_tb;
   localparam logic [127:0] EK = 128'h000102030405060708090a0b0c0d0e0f;
   localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
   localparam logic [127:0] CT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
   localparam logic [127:0] DK = 128'h13111d7fe3944a17f307a78b4d2b30c5;
   logic        clk, rst, psel, pen, pwr, pready, pslverr, irq, din_req, dout_req, tmo;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, c;
   logic [127:0] res [4] = '{CT, DK, PT, PT};
   int          err_count, num_checks;
   bce_engine #(.CYC_ENCRYPT(12), .CYC_KEYDERIV(11), .CYC_DECRYPT(12), .CYC_KDDECRYPT(22)) u_dut (
      .CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .IRQ_O(irq), .DMA_IN_REQ_O(din_req), .DMA_OUT_REQ_O(dout_req));
   bce_cpu_model u_cpu (.clk_i(clk), .prdata_i(prdata), .pready_i(pready), .psel_o(psel),
      .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata), .tmo_o(tmo));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_cpu.xfer(w, a, d, q);
      if (tmo) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   task automatic send(input logic [127:0] v);
      for (int i = 15; i >= 0; i--) bus(1'b1, 8'h08, {24'h0, v[i*8+:8]});
   endtask
   task automatic expect_blk(input logic [127:0] v);
      for (int i = 15; i >= 0; i--) begin
         bus(1'b0, 8'h0c, 32'h0);
         chk("data_out", {24'h0, v[i*8+:8]}, q);
      end
   endtask
   task automatic wait_done();
      int n = 0;
      do begin
         bus(1'b0, 8'h04, 32'h0);
         n++;
      end while (q[0] !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   task automatic wait_req(input logic o);
      int n = 0;
      repeat (2) @(posedge clk);
      while ((o ? dout_req : din_req) !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 8'h00, 32'h0);
      chk("control", 32'h0, q);
      bus(1'b0, 8'h04, 32'h0);
      chk("status", 32'h0, q);
      bus(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, q);
      for (int m = 0; m < 4; m++) begin
         c = {29'h0, m[1:0], 1'b1} | 32'h60;
         bus(1'b1, 8'h00, c & 32'hfe);
         bus(1'b1, 8'h00, c);
         if (m == 0) begin
            repeat (3) bus(1'b1, 8'h08, 32'haa);
            bus(1'b1, 8'h00, c & 32'hfe);
            bus(1'b1, 8'h00, c);
            bus(1'b0, 8'h0c, 32'h0);
         end
         send(m == 2 ? DK : EK);
         if (m != 1) send(m == 0 ? PT : CT);
         wait_done();
         chk("irq", 32'h1, {31'h0, irq});
         if (m == 0) begin
            bus(1'b1, 8'h08, 32'h55);
            bus(1'b0, 8'h04, 32'h0);
            chk("status errors", 32'h7, q);
            bus(1'b1, 8'h00, c | 32'h10);
         end
         expect_blk(res[m]);
         bus(1'b1, 8'h00, c | 32'h08);
         bus(1'b0, 8'h04, 32'h0);
         chk("status cleared", 32'h0, q);
         chk("irq cleared", 32'h0, {31'h0, irq});
         bus(1'b0, 8'h00, 32'h0);
         chk("control", c, q);
         $display("test mode %0d done", m);
      end
      send(EK);
      send(CT);
      wait_done();
      expect_blk(PT);
      $display("test second block done");
      bus(1'b1, 8'h00, 32'h00);
      bus(1'b1, 8'h00, 32'h81);
      for (int i = 31; i >= 0; i--) begin
         wait_req(1'b0);
         bus(1'b1, 8'h08, {24'h0, (i >= 16) ? EK[(i-16)*8+:8] : PT[i*8+:8]});
      end
      for (int i = 15; i >= 0; i--) begin
         wait_req(1'b1);
         bus(1'b0, 8'h0c, 32'h0);
         chk("dma data_out", {24'h0, CT[i*8+:8]}, q);
      end
      $display("test dma done");
      tally_and_finish();
   end
endmodule // byte_wide_block_cipher_engine_tb
